// [src/alz_pkg.sv]
// Constants and carrier types for the angle linearization stage.
// Assumes a 10 MHz system clock and a nonvolatile store that answers a read one cycle later.
// Overview of operation
// - Thirty-two stored coefficients correct the angle.
// - Coefficient k sits at k times 11.25 degrees.
// - Coefficient is subtracted from angle, never added.
// - Coefficients are 12-bit two's-complement values.
// - Scale bit doubles the weight per step.
// - Between breakpoints, interpolate linearly between neighbours.
// - Latency identical with correction on or off.
// - Disabled correction ignores coefficient storage.
// - Low-power tracking uses uncorrected angle only.
// - Wake when angle rate exceeds programmable threshold.
// - Default threshold keeps device awake above 100 RPM.
// - Wake decision uses uncorrected angle change only.
// - Reload coefficients and settings before producing angles.
package alz_pkg;
  localparam int ANG_W        = 15;
  localparam int COEF_W       = 12;
  localparam int NUM_COEF     = 32;
  localparam int SEG_W        = 5;
  localparam int FRAC_W       = ANG_W - SEG_W;
  localparam int NV_ADDR_W    = 6;
  // Nonvolatile word addresses.
  localparam logic [NV_ADDR_W-1:0] NV_ADR_CFG    = 6'h20;
  localparam logic [NV_ADDR_W-1:0] NV_ADR_THRESH = 6'h21;
  // Field positions in the configuration word.
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_SCALE_BIT = 1;
  // Reset values of the shadow settings.
  localparam logic [COEF_W-1:0] COEF_RST   = 12'h000;
  localparam logic              EN_RST     = 1'b0;
  localparam logic              SCALE_RST  = 1'b0;
  // 100 RPM is 600 deg/s; over 1 ms that is 0.6 deg, about 55 angle LSB.
  localparam logic [COEF_W-1:0] THRESH_RST = 12'h037;
  // Wake evaluation window and pipeline depth.
  localparam int CLK_MHZ      = 10;
  localparam int WAKE_WIN_US  = 1000;
  localparam int WAKE_WIN_CYC = WAKE_WIN_US * CLK_MHZ;
  localparam int PIPE_DEPTH   = 3;

  typedef struct packed {
    logic             valid;
    logic [ANG_W-1:0] angle;
  } alz_angle_t;
endpackage : alz_pkg

// [src/alz_linearizer.sv]
// Piecewise-linear angle correction between the angle datapath and the output formatters.
// Assumes angle samples are synchronous to SYS_CLK_IN and nonvolatile reads return in one cycle.
`timescale 1ns/10ps
module alz_linearizer #(
  parameter int WAKE_WIN = alz_pkg::WAKE_WIN_CYC
) (
  input  wire logic                               SYS_CLK_IN,
  input  wire logic                               RSTN_IN,
  input  wire alz_pkg::alz_angle_t                ANGLE_IN,
  input  wire logic                               LP_MODE_IN,
  input  wire logic [alz_pkg::COEF_W-1:0]         NV_DATA_IN,
  output      logic                               NV_RD_OUT,
  output      logic [alz_pkg::NV_ADDR_W-1:0]      NV_ADDR_OUT,
  output      alz_pkg::alz_angle_t                ANGLE_OUT,
  output      logic                               READY_OUT,
  output      logic                               WAKE_OUT
);
  import alz_pkg::*;

  typedef enum logic [1:0] {ST_LOAD, ST_RUN} alz_state_t;

  alz_state_t                 state;
  logic [COEF_W-1:0]          coef [NUM_COEF];
  logic                       lin_en;
  logic                       correction_scale_select;
  logic [COEF_W-1:0]          wake_thresh;
  logic                       rd_q;
  logic [NV_ADDR_W-1:0]       addr_q;

  function automatic logic signed [COEF_W:0] sext(input logic [COEF_W-1:0] c);
    sext = {c[COEF_W-1], c};
  endfunction : sext

  // Power-up shadow load: 32 coefficients, then configuration, then threshold.
  wire load_last = rd_q && (addr_q == NV_ADR_THRESH);
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      state       <= ST_LOAD;
      NV_RD_OUT   <= 1'b0;
      NV_ADDR_OUT <= 6'h00;
      rd_q        <= 1'b0;
      addr_q      <= 6'h00;
      READY_OUT   <= 1'b0;
    end else begin
      rd_q   <= NV_RD_OUT;
      addr_q <= NV_ADDR_OUT;
      case (state)
        ST_LOAD: begin
          // Once the threshold word is back the read must not restart, or the store sees a stray access.
          NV_RD_OUT <= (NV_ADDR_OUT != NV_ADR_THRESH) || (!NV_RD_OUT && !rd_q);
          if (NV_RD_OUT && NV_ADDR_OUT != NV_ADR_THRESH) begin
            NV_ADDR_OUT <= NV_ADDR_OUT + 6'h01;
          end
          if (NV_RD_OUT && NV_ADDR_OUT == NV_ADR_THRESH) begin
            NV_RD_OUT <= 1'b0;
          end
          if (load_last) begin
            state     <= ST_RUN;
            READY_OUT <= 1'b1;
          end
        end
        ST_RUN:  NV_RD_OUT <= 1'b0;
        default: state <= ST_LOAD;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COEF; gi++) begin : g_coef
      always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
          coef[gi] <= COEF_RST;
        end else if (rd_q && addr_q == NV_ADDR_W'(gi)) begin
          coef[gi] <= NV_DATA_IN;
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      lin_en                  <= EN_RST;
      correction_scale_select <= SCALE_RST;
      wake_thresh             <= THRESH_RST;
    end else begin
      if (rd_q && addr_q == NV_ADR_CFG) begin
        lin_en                  <= NV_DATA_IN[CFG_EN_BIT];
        correction_scale_select <= NV_DATA_IN[CFG_SCALE_BIT];
      end
      if (rd_q && addr_q == NV_ADR_THRESH) begin
        wake_thresh <= NV_DATA_IN;
      end
    end
  end

  // Stage 1: pick the two neighbouring breakpoints. Angles are refused until the shadow load ends.
  wire              in_take = ANGLE_IN.valid && READY_OUT;
  wire [SEG_W-1:0]  seg_lo  = ANGLE_IN.angle[ANG_W-1:FRAC_W];
  wire [SEG_W-1:0]  seg_hi  = seg_lo + 5'h01;
  wire [FRAC_W-1:0] frac_in = ANGLE_IN.angle[FRAC_W-1:0];

  logic                     v1;
  logic [ANG_W-1:0]         a1;
  logic signed [COEF_W:0]   c0;
  logic signed [COEF_W:0]   c1;
  logic [FRAC_W-1:0]        f1;
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      v1 <= 1'b0;
      a1 <= 15'h0000;
      c0 <= 13'h0000;
      c1 <= 13'h0000;
      f1 <= 10'h000;
    end else begin
      v1 <= in_take;
      a1 <= ANGLE_IN.angle;
      c0 <= sext(coef[seg_lo]);
      c1 <= sext(coef[seg_hi]);
      f1 <= frac_in;
    end
  end

  // Stage 2: interpolated correction. One coefficient LSB equals one angle LSB at the low scale.
  wire signed [COEF_W+1:0]        cdiff = (COEF_W+2)'(c1) - (COEF_W+2)'(c0);
  wire signed [COEF_W+FRAC_W+2:0] prod  = cdiff * $signed({1'b0, f1});
  wire signed [COEF_W+1:0]        step  = (COEF_W+2)'(prod >>> FRAC_W);
  wire signed [COEF_W+1:0]        corr  = (COEF_W+2)'(c0) + step;

  logic                     v2;
  logic [ANG_W-1:0]         a2;
  logic signed [COEF_W+1:0] corr2;
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      v2    <= 1'b0;
      a2    <= 15'h0000;
      corr2 <= 14'h0000;
    end else begin
      v2    <= v1;
      a2    <= a1;
      corr2 <= correction_scale_select ? (corr <<< 1) : corr;
    end
  end

  // Stage 3: subtract and wrap modulo a full turn. The raw path keeps the same depth.
  wire [ANG_W-1:0] lin_ang = a2 - ANG_W'(corr2);
  wire [ANG_W-1:0] sel_ang = lin_en ? lin_ang : a2;
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      ANGLE_OUT <= '0;
    end else begin
      ANGLE_OUT.valid <= v2;
      ANGLE_OUT.angle <= sel_ang;
    end
  end

  // Wake tracker on the raw input angle; the corrected path is never consulted.
  logic [31:0]      win_cnt;
  logic [ANG_W-1:0] ref_ang;
  wire              win_end = LP_MODE_IN && (win_cnt == 32'(WAKE_WIN - 1));
  wire [ANG_W-1:0]  dang    = ANGLE_IN.angle - ref_ang;
  wire [ANG_W-1:0]  dabs    = dang[ANG_W-1] ? (~dang + 15'h0001) : dang;
  wire              fast    = dabs > ANG_W'(wake_thresh);
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      win_cnt  <= 32'h0000_0000;
      ref_ang  <= 15'h0000;
      WAKE_OUT <= 1'b0;
    end else begin
      WAKE_OUT <= win_end && fast;
      if (!LP_MODE_IN || win_end) begin
        win_cnt <= 32'h0000_0000;
        ref_ang <= ANGLE_IN.angle;
      end else begin
        win_cnt <= win_cnt + 32'h0000_0001;
      end
    end
  end

  // Helper for the breakpoint check: scaled coefficient at the incoming segment.
  wire signed [COEF_W+1:0] bp_corr = correction_scale_select ? ((COEF_W+2)'(sext(coef[seg_lo])) <<< 1)
                                                             : (COEF_W+2)'(sext(coef[seg_lo]));
  wire signed [COEF_W:0]   c_min   = (c0 < c1) ? c0 : c1;
  wire signed [COEF_W:0]   c_max   = (c0 < c1) ? c1 : c0;

  AST_LATENCY: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    in_take |-> ##3 ANGLE_OUT.valid)
    else $error("Angle did not emerge three cycles after input.");
  AST_NO_EARLY: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    !READY_OUT |-> !ANGLE_OUT.valid)
    else $error("Angle produced before settings were loaded.");
  AST_BYPASS: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (in_take && !lin_en) ##3 !lin_en |-> ANGLE_OUT.angle == $past(ANGLE_IN.angle, 3))
    else $error("Disabled correction altered the angle.");
  AST_BREAKPOINT: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (in_take && lin_en && frac_in == 10'h000) |->
      ##3 ANGLE_OUT.angle == ANG_W'($past(ANGLE_IN.angle, 3) - ANG_W'($past(bp_corr, 3))))
    else $error("Breakpoint output is not angle minus coefficient.");
  AST_INTERP: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (v1 && !correction_scale_select) ##1 !correction_scale_select |->
      (corr2 >= (COEF_W+2)'($past(c_min))) && (corr2 <= (COEF_W+2)'($past(c_max))))
    else $error("Interpolated correction outside neighbour span.");
  AST_SCALE: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    correction_scale_select && $stable(correction_scale_select) && v2 |-> corr2[0] == 1'b0)
    else $error("Doubled scale gave an odd correction.");
  AST_WAKE: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (win_end && fast) |=> WAKE_OUT ##1 !WAKE_OUT)
    else $error("Wake pulse missing or too long.");
  AST_WAKE_LP: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    WAKE_OUT |-> $past(LP_MODE_IN) && $past(dabs) > ANG_W'($past(wake_thresh)))
    else $error("Wake without fast raw rotation in low power.");
  AST_LOAD: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    $rose(READY_OUT) |-> $past(rd_q) && $past(addr_q) == NV_ADR_THRESH)
    else $error("Ready rose before the shadow load completed.");
  // The store stays untouched after the load, so user words there are never read back.
  AST_NV_QUIET: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    READY_OUT |-> !NV_RD_OUT)
    else $error("Store read after the shadow load finished.");
  AST_READY_HOLD: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    READY_OUT |=> READY_OUT)
    else $error("Ready dropped without a reset.");
  AST_RAW_PATH: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (v2 && !lin_en) |=> ANGLE_OUT.angle == $past(a2))
    else $error("Raw path did not pass the uncorrected angle.");
endmodule : alz_linearizer

// [tb/alz_nv_model.sv]
// Behavioural nonvolatile store that answers the linearizer's shadow load.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/10ps
module alz_nv_model (
  input  wire logic                         clk_in,
  input  wire logic                         rd_in,
  input  wire logic [alz_pkg::NV_ADDR_W-1:0] addr_in,
  output      logic [alz_pkg::COEF_W-1:0]    data_out
);
  logic [alz_pkg::COEF_W-1:0] mem [0:33];
  logic [alz_pkg::COEF_W-1:0] last = '0;
  initial data_out = '0;
  // Outside a read the lines show the inverse of the last word, so a late capture is caught.
  always @(posedge clk_in) begin
    if (rd_in) begin
      data_out <= mem[addr_in];
      last     <= mem[addr_in];
    end else begin
      data_out <= ~last;
    end
  end
endmodule : alz_nv_model

// [tb/alz_linearizer_tb.sv]
// Self-checking bench for the angle linearizer with an integer reference model.
// Assumes the nonvolatile model above and a short wake window of 16 cycles.
`timescale 1ns/10ps
module alz_linearizer_tb;
  import alz_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, lp = 1'b0, nv_rd, ready, wake, en, scl;
  alz_angle_t ang_in = '0, ang_out;
  logic [COEF_W-1:0] nv_data, coef [0:31];
  logic [NV_ADDR_W-1:0] nv_addr;
  int bad_count = 0, checks = 0, cyc = 0, wakes = 0;
  int exp_q[$], due_q[$];
  localparam int WIN = 16;
  int nv_exp = 0, wcnt = 0, wref = 0, wd = 0;
  logic wexp = 1'b0;
  always #50 sys_clk = ~sys_clk;
  alz_linearizer #(.WAKE_WIN(WIN)) u_alz_linearizer (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn), .ANGLE_IN(ang_in),
    .LP_MODE_IN(lp), .NV_DATA_IN(nv_data), .NV_RD_OUT(nv_rd), .NV_ADDR_OUT(nv_addr), .ANGLE_OUT(ang_out),
    .READY_OUT(ready), .WAKE_OUT(wake));
  alz_nv_model u_alz_nv_model (.clk_in(sys_clk), .rd_in(nv_rd), .addr_in(nv_addr), .data_out(nv_data));
  task automatic check_ang(input logic [ANG_W-1:0] got, input logic [ANG_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_ang
  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Reference: interpolate between neighbours, last segment runs toward coefficient zero.
  function automatic int expv(input int a);
    int seg, c0, c1, corr;
    seg = a >> 10;
    c0 = int'($signed(coef[seg]));
    c1 = int'($signed(coef[(seg + 1) % 32]));
    corr = c0 + (((c1 - c0) * (a & 1023)) >>> 10);
    if (scl) corr = corr * 2;
    return en ? ((a - corr) & 32'h0000_7FFF) : a;
  endfunction : expv
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (ang_in.valid && ready === 1'b1) begin
      exp_q.push_back(expv(int'(ang_in.angle)));
      due_q.push_back(cyc + PIPE_DEPTH);
    end
    if (ang_out.valid !== 1'b0) begin
      if (exp_q.size() == 0) check_bit(ang_out.valid, 1'b0);
      else begin
        check_ang(ang_out.angle, ANG_W'(exp_q.pop_front()));
        check_bit(cyc == due_q.pop_front(), 1'b1);
      end
    end else if (due_q.size() > 0 && due_q[0] <= cyc) begin
      check_bit(ang_out.valid, 1'b1);
      void'(exp_q.pop_front());
      void'(due_q.pop_front());
    end
  end
  // Independent reference for the load order and the wake pulse, compared at every edge.
  always @(posedge sys_clk) begin
    if (rstn !== 1'b1) begin
      nv_exp <= 0;
      wcnt   <= 0;
      wref   <= 0;
      wexp   <= 1'b0;
    end else begin
      check_bit(wake, wexp);
      if (ready === 1'b1) check_bit(nv_rd, 1'b0);
      if (nv_rd !== 1'b0) begin
        check_ang(ANG_W'(nv_addr), ANG_W'(nv_exp));
        nv_exp <= nv_exp + 1;
      end
      wd = (int'(ang_in.angle) - wref) & 32'h0000_7FFF;
      if (wd >= 16384) wd = 32768 - wd;
      wexp <= (lp === 1'b1) && (wcnt == WIN - 1) && (wd > int'(THRESH_RST));
      if (lp !== 1'b1 || wcnt == WIN - 1) begin
        wcnt <= 0;
        wref <= int'(ang_in.angle);
      end else begin
        wcnt <= wcnt + 1;
      end
    end
  end
  always @(negedge sys_clk) if (wake === 1'b1) wakes++;
  task automatic send(input int a);
    ang_in <= {1'b1, ANG_W'(a)};
    @(posedge sys_clk);
  endtask : send
  task automatic run_cfg(input int t, input logic e, input logic s);
    int n;
    en = e;
    scl = s;
    for (int i = 0; i < 32; i++) coef[i] = COEF_W'($urandom);
    coef[0] = 12'h07FF;
    coef[1] = 12'h0800;
    for (int i = 0; i < 32; i++) u_alz_nv_model.mem[i] = coef[i];
    u_alz_nv_model.mem[32] = {10'h000, s, e};
    u_alz_nv_model.mem[33] = THRESH_RST;
    rstn <= 1'b0;
    lp <= 1'b0;
    ang_in <= '0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 60) begin
      send(int'($urandom_range(32767)));
      n++;
    end
    check_bit(ready, 1'b1);
    check_bit(n >= 34, 1'b1);
    check_bit(nv_exp == 34, 1'b1);
    for (int k = 0; k < 32; k++) send(k * 1024);
    send(32767);
    send(31 * 1024 + 512);
    repeat (60) send(int'($urandom_range(32767)));
    lp <= 1'b1;
    wakes = 0;
    for (int k = 0; k < 48; k++) send(k * 300);
    check_bit(wakes > 0, 1'b1);
    repeat (20) send(100);
    wakes = 0;
    // A slow raw ramp in the steep first segment: the corrected angle moves fast, the raw one does not.
    for (int i = 0; i < 40; i++) send(100 + i);
    check_bit(wakes == 0, 1'b1);
    ang_in <= '0;
    repeat (6) @(posedge sys_clk);
    check_bit(exp_q.size() == 0, 1'b1);
    $display("test %0d done", t);
  endtask : run_cfg
  initial begin
    void'($urandom(32'hDEAF_9BF0));
    run_cfg(1, 1'b1, 1'b0);
    run_cfg(2, 1'b1, 1'b1);
    run_cfg(3, 1'b0, 1'b1);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
endmodule : alz_linearizer_tb
